// ### rtl/codec_bypass_page_coef_regs.sv
`timescale 1ns/1ps
// Operation
// - Right-plus bypass bits route each first/second input to right line output.
// - Left-plus bypass bits route each first/second input to left line output.
// - DAC current field: 00 default, 01 plus half, 11 double, 10 reserved.
// - Page 0 addresses 110 to 127 read zero; writes to them are ignored.
// - Page bit 0 selects page 0, 1 selects page 1; resets 0.
// - Page select lives at address 0 on both pages, same behaviour.
// - Coefficient is MSB and LSB concatenated as signed 16-bit value.
// - Coefficient zero resets to 6b e3.
// - Coefficient one resets to 96 66, at page 1 addresses 3 and 4.
module codec_bypass_page_coef_regs
  import codec_regs_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [6:0] ADDR,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  output logic ACTIVE_PAGE,
  output logic SECOND_LINE_IN_RIGHT_PLUS_BYPASS,
  output logic FIRST_LINE_IN_RIGHT_PLUS_BYPASS,
  output logic SECOND_LINE_IN_LEFT_PLUS_BYPASS,
  output logic FIRST_LINE_IN_LEFT_PLUS_BYPASS,
  output logic BYPASS_SHORT_WARN,
  output logic [1:0] DAC_CURRENT_CODE,
  output logic [1:0] DAC_CURRENT_STEP,
  output logic signed [15:0] EFFECTS_COEF_ZERO,
  output logic signed [15:0] EFFECTS_COEF_ONE
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic page_r;
  logic [7:0] bypass_r;
  logic [7:0] dac_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] c0_hi;
  logic [7:0] c0_lo;
  logic [7:0] c1_hi;
  logic [7:0] c1_lo;
  logic wr;
  logic p0;
  logic p1;

  // Every write is qualified by the clock enable, so a frozen block ignores the bus
  assign wr = CE && WR_EN;
  assign p0 = (page_r == 1'b0);
  assign p1 = (page_r == 1'b1);

  // ----------------------------------------
  // Page select, visible at address 0 of either page
  // ----------------------------------------
  // Only bit 0 is stored, so upper reserved bits always read zero
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      page_r <= 1'b0;
    end else if (wr && ADDR == ADDR_PAGE_SELECT) begin
      page_r <= WDATA[BIT_PAGE];
    end
  end

  // ----------------------------------------
  // Page 0 control registers
  // ----------------------------------------
  // Reserved bits are not stored; a careless host cannot set them
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      bypass_r <= RST_ZERO;
      dac_r <= RST_ZERO;
    end else if (wr && p0) begin
      if (ADDR == ADDR_BYPASS_SELECT) bypass_r <= WDATA & BYPASS_WR_MASK;
      if (ADDR == ADDR_DAC_CURRENT) dac_r <= WDATA & DAC_WR_MASK;
    end
  end

  // ----------------------------------------
  // Page 1 coefficient pairs
  // ----------------------------------------
  coef_pair #(.RST_HIGH(RST_COEF0_HIGH), .RST_LOW(RST_COEF0_LOW)) u_coef0 (
    .clk(CLK),
    .resetn(RESETN),
    .ce(CE),
    .wr_high(WR_EN && p1 && ADDR == ADDR_COEF0_HIGH),
    .wr_low(WR_EN && p1 && ADDR == ADDR_COEF0_LOW),
    .wdata(WDATA),
    .high_rd(c0_hi),
    .low_rd(c0_lo),
    .coef(EFFECTS_COEF_ZERO)
  );
  coef_pair #(.RST_HIGH(RST_COEF1_HIGH), .RST_LOW(RST_COEF1_LOW)) u_coef1 (
    .clk(CLK),
    .resetn(RESETN),
    .ce(CE),
    .wr_high(WR_EN && p1 && ADDR == ADDR_COEF1_HIGH),
    .wr_low(WR_EN && p1 && ADDR == ADDR_COEF1_LOW),
    .wdata(WDATA),
    .high_rd(c1_hi),
    .low_rd(c1_lo),
    .coef(EFFECTS_COEF_ONE)
  );

  // ----------------------------------------
  // Read path, one cycle latency
  // ----------------------------------------
  // Unmapped and reserved addresses read zero
  always_comb begin
    rdata_nxt = RST_ZERO;
    if (ADDR == ADDR_PAGE_SELECT) begin
      rdata_nxt = {7'h00, page_r};
    end else if (p0) begin
      if (ADDR == ADDR_BYPASS_SELECT) rdata_nxt = bypass_r;
      else if (ADDR == ADDR_DAC_CURRENT) rdata_nxt = dac_r;
      else if (ADDR >= ADDR_RSVD_FIRST) rdata_nxt = RST_ZERO;
    end else begin
      case (ADDR)
        ADDR_COEF0_HIGH: rdata_nxt = c0_hi;
        ADDR_COEF0_LOW: rdata_nxt = c0_lo;
        ADDR_COEF1_HIGH: rdata_nxt = c1_hi;
        ADDR_COEF1_LOW: rdata_nxt = c1_lo;
        default: rdata_nxt = RST_ZERO;
      endcase
    end
  end

  // RDATA holds the last read, so a slow host may still take it a cycle late
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_r <= RST_ZERO;
    end else if (CE && RD_EN) begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Decoded outputs
  // ----------------------------------------
  assign RDATA = rdata_r;
  assign ACTIVE_PAGE = page_r;
  assign SECOND_LINE_IN_RIGHT_PLUS_BYPASS = bypass_r[BIT_SECOND_RIGHT];
  assign FIRST_LINE_IN_RIGHT_PLUS_BYPASS = bypass_r[BIT_FIRST_RIGHT];
  assign SECOND_LINE_IN_LEFT_PLUS_BYPASS = bypass_r[BIT_SECOND_LEFT];
  assign FIRST_LINE_IN_LEFT_PLUS_BYPASS = bypass_r[BIT_FIRST_LEFT];
  // Flags the shorting hazard; the device does not block it
  assign BYPASS_SHORT_WARN = (bypass_r[BIT_SECOND_RIGHT] && bypass_r[BIT_FIRST_RIGHT]) ||
                             (bypass_r[BIT_SECOND_LEFT] && bypass_r[BIT_FIRST_LEFT]);
  assign DAC_CURRENT_CODE = dac_r[DAC_ADJ_HI:DAC_ADJ_LO];

  // Step 0 none, 1 plus half, 2 double; reserved code falls back to default
  always_comb begin
    case (dac_r[DAC_ADJ_HI:DAC_ADJ_LO])
      DAC_ADJ_DEFAULT: DAC_CURRENT_STEP = 2'h0;
      DAC_ADJ_PLUS50: DAC_CURRENT_STEP = 2'h1;
      DAC_ADJ_PLUS100: DAC_CURRENT_STEP = 2'h2;
      DAC_ADJ_RSVD: DAC_CURRENT_STEP = 2'h0;
      default: DAC_CURRENT_STEP = 2'h0;
    endcase
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // One clock domain, so clocking and reset are given once for all checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // Bus side: page bit, read path, reserved range and the frozen state
  a_page_write: assert property (wr && ADDR == ADDR_PAGE_SELECT
    |=> page_r == $past(WDATA[0]))
    else $error("page bit did not follow write");
  // A read that meets a page write in one cycle still sees the old bit
  a_page_read: assert property (CE && RD_EN && ADDR == ADDR_PAGE_SELECT
    |=> RDATA == {7'h00, $past(page_r)})
    else $error("page select readback wrong");
  a_rsvd_zero: assert property (CE && RD_EN && p0 && ADDR >= ADDR_RSVD_FIRST
    |=> RDATA == 8'h00)
    else $error("reserved range read nonzero");
  a_rsvd_write: assert property (wr && p0 && ADDR >= ADDR_RSVD_FIRST
    |=> $stable(bypass_r) && $stable(dac_r))
    else $error("write to reserved range took effect");
  a_ce_freeze: assert property (!CE
    |=> $stable(page_r) && $stable(bypass_r) && $stable(dac_r) && $stable(RDATA)
        && $stable(EFFECTS_COEF_ZERO) && $stable(EFFECTS_COEF_ONE))
    else $error("state moved while clock enable low");

  // Decode side: bypass switches and DAC current step
  a_bypass_map: assert property (wr && p0 && ADDR == ADDR_BYPASS_SELECT
    |=> FIRST_LINE_IN_LEFT_PLUS_BYPASS == $past(WDATA[0])
        && SECOND_LINE_IN_RIGHT_PLUS_BYPASS == $past(WDATA[6]))
    else $error("bypass bit mapping wrong");
  a_bypass_right: assert property (wr && p0 && ADDR == ADDR_BYPASS_SELECT
    |=> FIRST_LINE_IN_RIGHT_PLUS_BYPASS == $past(WDATA[4]))
    else $error("right bypass bit wrong");
  a_bypass_left: assert property (wr && p0 && ADDR == ADDR_BYPASS_SELECT
    |=> SECOND_LINE_IN_LEFT_PLUS_BYPASS == $past(WDATA[2]))
    else $error("left bypass bit wrong");
  a_dac_step: assert property (DAC_CURRENT_CODE == DAC_ADJ_PLUS100
    |-> DAC_CURRENT_STEP == 2'h2)
    else $error("dac step decode wrong");
  a_dac_rsvd: assert property (DAC_CURRENT_CODE == DAC_ADJ_RSVD
    |-> DAC_CURRENT_STEP == 2'h0)
    else $error("reserved dac code not at default");

  // Coefficients: an MSB write alone never moves the live value
  a_coef_hold: assert property (CE && WR_EN && p1 && ADDR == ADDR_COEF0_HIGH
    ##1 !(CE && WR_EN && ADDR == ADDR_COEF0_LOW) |-> $stable(EFFECTS_COEF_ZERO))
    else $error("coefficient changed on msb write");
  a_coef_commit: assert property (CE && WR_EN && p1 && ADDR == ADDR_COEF1_LOW
    |=> EFFECTS_COEF_ONE == {c1_hi, $past(WDATA)})
    else $error("coefficient commit wrong");
  a_coef0_commit: assert property (CE && WR_EN && p1 && ADDR == ADDR_COEF0_LOW
    |=> EFFECTS_COEF_ZERO == {c0_hi, $past(WDATA)})
    else $error("coefficient zero commit wrong");

  // Main scenarios; the host leaves an idle cycle between the two coefficient bytes
  c_page_flip: cover property (wr && ADDR == ADDR_PAGE_SELECT ##1 page_r);
  c_coef_pair: cover property (wr && p1 && ADDR == ADDR_COEF0_HIGH
    ##[1:2] wr && ADDR == ADDR_COEF0_LOW);
  c_short: cover property (BYPASS_SHORT_WARN);
  c_dac_rsvd: cover property (DAC_CURRENT_CODE == DAC_ADJ_RSVD);
  c_ce_hold: cover property (!CE && WR_EN);
endmodule

// ### rtl/codec_regs_pkg.sv
package codec_regs_pkg;
  // ----------------------------------------
  // Register addresses (7-bit, per page)
  // ----------------------------------------
  localparam logic [6:0] ADDR_PAGE_SELECT = 7'h00;
  localparam logic [6:0] ADDR_BYPASS_SELECT = 7'h6c;
  localparam logic [6:0] ADDR_DAC_CURRENT = 7'h6d;
  localparam logic [6:0] ADDR_RSVD_FIRST = 7'h6e;
  localparam logic [6:0] ADDR_COEF0_HIGH = 7'h01;
  localparam logic [6:0] ADDR_COEF0_LOW = 7'h02;
  localparam logic [6:0] ADDR_COEF1_HIGH = 7'h03;
  localparam logic [6:0] ADDR_COEF1_LOW = 7'h04;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_SECOND_RIGHT = 6;
  localparam int BIT_FIRST_RIGHT = 4;
  localparam int BIT_SECOND_LEFT = 2;
  localparam int BIT_FIRST_LEFT = 0;
  localparam int DAC_ADJ_HI = 7;
  localparam int DAC_ADJ_LO = 6;
  localparam int BIT_PAGE = 0;
  localparam logic [7:0] BYPASS_WR_MASK = 8'h55;
  localparam logic [7:0] DAC_WR_MASK = 8'hc0;
  // ----------------------------------------
  // Reset values and encodings
  // ----------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_COEF0_HIGH = 8'h6b;
  localparam logic [7:0] RST_COEF0_LOW = 8'he3;
  localparam logic [7:0] RST_COEF1_HIGH = 8'h96;
  localparam logic [7:0] RST_COEF1_LOW = 8'h66;
  localparam logic [1:0] DAC_ADJ_DEFAULT = 2'h0;
  localparam logic [1:0] DAC_ADJ_PLUS50 = 2'h1;
  localparam logic [1:0] DAC_ADJ_RSVD = 2'h2;
  localparam logic [1:0] DAC_ADJ_PLUS100 = 2'h3;
endpackage

// ### rtl/coef_pair.sv
`timescale 1ns/1ps
// One coefficient: MSB shadow, LSB commit into the live 16-bit value
module coef_pair
  import codec_regs_pkg::*;
#(
  parameter logic [7:0] RST_HIGH = 8'h00,
  parameter logic [7:0] RST_LOW = 8'h00
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic wr_high,
  input wire logic wr_low,
  input wire logic [7:0] wdata,
  output logic [7:0] high_rd,
  output logic [7:0] low_rd,
  output logic signed [15:0] coef
);
  logic [7:0] shadow_r;
  logic [7:0] low_r;
  logic signed [15:0] live_r;

  // Shadow holds the MSB until its LSB arrives
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shadow_r <= RST_HIGH;
      low_r <= RST_LOW;
    end else if (ce) begin
      if (wr_high) shadow_r <= wdata;
      if (wr_low) low_r <= wdata;
    end
  end

  // Filter sees only whole pairs, never a half update
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      live_r <= {RST_HIGH, RST_LOW};
    end else if (ce && wr_low) begin
      live_r <= {shadow_r, wdata};
    end
  end

  assign high_rd = shadow_r;
  assign low_rd = low_r;
  assign coef = live_r;
endmodule

// ### testbench/host_model.sv
`timescale 1ns/1ps
// Host controller: drives the control bus off the falling edge, one access per access call
module host_model
  import codec_regs_pkg::*;
(
  input wire logic clk,
  output logic ce,
  output logic wr_en,
  output logic rd_en,
  output logic [6:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata
);
  // Bus idle from time zero
  initial begin
    ce = 1'h0;
    wr_en = 1'h0;
    rd_en = 1'h0;
    addr = 7'h00;
    wdata = 8'h00;
  end

  // Raw access, held across one taking edge; read data lands one edge later
  task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d,
                        input logic en, output logic [7:0] q);
    @(negedge clk);
    ce = en;
    wr_en = w;
    rd_en = !w;
    addr = a;
    wdata = d;
    @(negedge clk);
    q = rdata;
    ce = 1'h0;
    wr_en = 1'h0;
    rd_en = 1'h0;
    addr = ~a; // Released lines never keep the stale value
    wdata = ~d;
  endtask

  // Polite write: reserved bits zero, no shorted bypass pair, read-only range left alone
  task automatic wr(input logic [6:0] a, input logic [7:0] d, output logic [7:0] sent);
    logic [7:0] q;
    sent = d;
    if (a == ADDR_BYPASS_SELECT) begin
      sent = d & BYPASS_WR_MASK & ~{1'h0, d[4], 3'h0, d[0], 2'h0};
    end
    if (a == ADDR_DAC_CURRENT) begin
      sent = d & DAC_WR_MASK;
    end
    if (a == ADDR_PAGE_SELECT) begin
      sent = d & 8'h01;
    end
    if (a < ADDR_RSVD_FIRST) begin
      access(1'h1, a, sent, 1'h1, q);
    end
  endtask

  // Page switch always followed by a read-back of the page bit
  task automatic page(input logic p, output logic [7:0] q);
    logic [7:0] s;
    wr(ADDR_PAGE_SELECT, {7'h00, p}, s);
    access(1'h0, ADDR_PAGE_SELECT, 8'h00, 1'h1, q);
  endtask
endmodule

// ### testbench/test_codec_bypass_page_coef_regs.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", nm, (e), (g)); end end
module test_codec_bypass_page_coef_regs
  import codec_regs_pkg::*;
();
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic ce, wr_en, rd_en, active_page, warn;
  logic [6:0] addr, ha;
  logic [7:0] wdata, rdata, q, w;
  logic [3:0] byp;
  logic [1:0] dac_code, dac_step;
  logic signed [15:0] coef0, coef1, c, old;
  logic [7:0] rst_tab [4] = '{8'h6b, 8'he3, 8'h96, 8'h66};
  logic [31:0] seed = 32'h56;
  int miscompares = 0;
  int n_compared = 0;

  always #12.5 clk = ~clk;

  codec_bypass_page_coef_regs u_codec_bypass_page_coef_regs (.CLK(clk), .RESETN(resetn),
    .CE(ce), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr), .WDATA(wdata), .RDATA(rdata),
    .ACTIVE_PAGE(active_page), .SECOND_LINE_IN_RIGHT_PLUS_BYPASS(byp[3]),
    .FIRST_LINE_IN_RIGHT_PLUS_BYPASS(byp[2]), .SECOND_LINE_IN_LEFT_PLUS_BYPASS(byp[1]),
    .FIRST_LINE_IN_LEFT_PLUS_BYPASS(byp[0]), .BYPASS_SHORT_WARN(warn),
    .DAC_CURRENT_CODE(dac_code), .DAC_CURRENT_STEP(dac_step),
    .EFFECTS_COEF_ZERO(coef0), .EFFECTS_COEF_ONE(coef1));

  host_model u_host_model (.clk(clk), .ce(ce), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata));

  // Xorshift source, fixed start so every run repeats
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Reserved code 10 falls back to the default current
  function automatic logic [1:0] exp_step(input logic [1:0] code);
    return (code == 2'h1) ? 2'h1 : (code == 2'h3) ? 2'h2 : 2'h0;
  endfunction

  task automatic wrap_up();
    if (miscompares == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog sized well beyond the roughly 165 cycles the sequence needs
  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    resetn = 1'h1;
    `CHK("page", 1'h0, active_page)
    `CHK("coef0", 16'h6be3, coef0)
    `CHK("coef1", 16'h9666, coef1)
    u_host_model.access(1'h1, 7'h7f, 8'hff, 1'h1, q); // Deliberate write to read-only range
    for (int a = 'h6e; a < 'h80; a++) begin
      u_host_model.access(1'h0, 7'(a), 8'h00, 1'h1, q);
      `CHK("rsvd", 8'h00, q)
    end
    for (int i = 0; i < 8; i++) begin
      u_host_model.wr(ADDR_BYPASS_SELECT, 8'(rnd()), w);
      `CHK("byp_right", {w[6], w[4]}, byp[3:2])
      `CHK("byp_left", {w[2], w[0]}, byp[1:0])
      `CHK("warn_off", 1'h0, warn)
    end
    // Careless host: reserved bits dropped, both pairs shorted
    u_host_model.access(1'h1, ADDR_BYPASS_SELECT, 8'hff, 1'h1, q);
    u_host_model.access(1'h0, ADDR_BYPASS_SELECT, 8'h00, 1'h1, q);
    `CHK("byp_rd", 8'h55, q)
    `CHK("warn", 1'h1, warn)
    u_host_model.access(1'h1, ADDR_BYPASS_SELECT, 8'h00, 1'h0, q);
    `CHK("ce_low", 4'hf, byp)
    for (int k = 0; k < 4; k++) begin
      u_host_model.wr(ADDR_DAC_CURRENT, {2'(k), 6'(rnd())}, w);
      `CHK("dac_code", 2'(k), dac_code)
      `CHK("dac_step", exp_step(2'(k)), dac_step)
    end
    u_host_model.access(1'h0, ADDR_DAC_CURRENT, 8'h00, 1'h1, q);
    `CHK("dac_rd", {DAC_ADJ_PLUS100, 6'h00}, q)
    u_host_model.page(1'h1, q);
    `CHK("page_rd", 8'h01, q)
    `CHK("page", 1'h1, active_page)
    for (int k = 1; k < 5; k++) begin
      u_host_model.access(1'h0, 7'(k), 8'h00, 1'h1, q);
      `CHK("coef_rst", rst_tab[k-1], q)
    end
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 16'h8000 : (i == 1) ? 16'h7fff : 16'(rnd());
      ha = i[0] ? ADDR_COEF1_HIGH : ADDR_COEF0_HIGH;
      old = i[0] ? coef1 : coef0;
      u_host_model.wr(ha, c[15:8], w);
      `CHK("shadow", old, i[0] ? coef1 : coef0)
      u_host_model.wr(ha + 7'h1, c[7:0], w);
      `CHK("coef", c, i[0] ? coef1 : coef0)
      u_host_model.access(1'h0, ha, 8'h00, 1'h1, q);
      `CHK("coef_hi", c[15:8], q)
      u_host_model.access(1'h0, ha + 7'h1, 8'h00, 1'h1, q);
      `CHK("coef_lo", c[7:0], q)
    end
    u_host_model.page(1'h0, q);
    `CHK("page_rd", 8'h00, q)
    `CHK("page", 1'h0, active_page)
    u_host_model.access(1'h0, ADDR_BYPASS_SELECT, 8'h00, 1'h1, q);
    `CHK("page0_rd", 8'h55, q)
    wrap_up();
  end
endmodule
